// >>> inc/stream_table_pkg.sv
// Purpose: Shared constants for the stream table configuration block.
// Assumes: Registers reached as 32-bit words on a simple word port.
// Notes:   Offsets are byte addresses of 32-bit words.
package stream_table_pkg;

    // Register word offsets.
    localparam logic [7:0] OFS_BASE_LO = 8'h80;
    localparam logic [7:0] OFS_BASE_HI = 8'h84;
    localparam logic [7:0] OFS_CFG     = 8'h88;

    // Base register field positions.
    localparam int BASE_ADDR_MSB = 51;
    localparam int BASE_ADDR_LSB = 6;
    localparam int BASE_RA_BIT   = 62;

    // Configuration register field positions.
    localparam int CFG_FMT_LSB   = 16;
    localparam int CFG_SPLIT_LSB = 6;
    localparam int CFG_SIZE_LSB  = 0;

    // Format encodings.
    localparam logic [1:0] FMT_LINEAR = 2'h0;
    localparam logic [1:0] FMT_TWO_LV = 2'h1;

    // Split encodings.
    localparam logic [4:0] SPLIT_4K  = 5'h06;
    localparam logic [4:0] SPLIT_16K = 5'h08;
    localparam logic [4:0] SPLIT_64K = 5'h0A;

    // Minimum two-level alignment exponent minus one (64 bytes).
    localparam logic [6:0] MIN_ALIGN_TOP = 7'h05;
    localparam logic [6:0] LINEAR_ADD    = 7'h05;
    localparam logic [6:0] TWO_LV_ADD    = 7'h02;

    // Identification-free implementation choices.
    localparam logic [5:0] SID_WIDTH    = 6'h10;
    localparam logic [6:0] OUT_ADDR_BITS = 7'h30;

    // Reset values used when tables are fixed.
    localparam logic [63:0] BASE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

endpackage

// >>> inc/lookup_if.sv
// Purpose: Carries decoded table configuration to the index calculator.
// Assumes: Single clock domain.
// Notes:   Size is the stored register value; format and split arrive decoded.
interface lookup_if;
    logic        two_level;
    logic [4:0]  split_bits;
    logic [5:0]  size_raw;
    logic [15:0] stream_id;
    logic [15:0] upper_index;
    logic [15:0] leaf_index;
    logic        out_of_range;

    modport cfg  (output two_level, output split_bits, output size_raw, output stream_id,
                  input upper_index, input leaf_index, input out_of_range);
    modport calc (input two_level, input split_bits, input size_raw, input stream_id,
                  output upper_index, output leaf_index, output out_of_range);
endinterface

// >>> hw/stream_index_calc.sv
// Purpose: Combinational split and range logic for one stream identifier.
// Assumes: Configuration fields come already decoded from registers.
// Notes:   Size is capped at the supported identifier width here.
module stream_index_calc
    import stream_table_pkg::*;
(
    lookup_if.calc lk
);
    logic [5:0]  size_eff;
    logic [4:0]  split_eff;
    logic [16:0] id_limit;

    assign size_eff  = (lk.size_raw > SID_WIDTH) ? SID_WIDTH : lk.size_raw;
    assign split_eff = lk.two_level ? lk.split_bits : 5'h00;
    assign id_limit  = 17'h1_0000 >> (6'h10 - size_eff);

    assign lk.out_of_range = ({1'b0, lk.stream_id} >= id_limit);

    always_comb begin
        lk.leaf_index  = lk.stream_id & ((16'h0001 << split_eff) - 16'h0001);
        lk.upper_index = lk.two_level ? (lk.stream_id >> split_eff) : 16'h0000;
        if (lk.two_level && ({1'b0, split_eff} >= size_eff)) begin
            lk.upper_index = 16'h0000;
        end
    end

endmodule

// >>> hw/stream_table_config.sv
// Purpose: Stream table base and format registers with derived lookup info.
// Assumes: Word register port, one clock, synchronous active-low reset.
// Notes:   Lookup results are registered one cycle after lookup_valid.
//
// Operation
// - Base holds address bits 51 to 6 and the bit 62 hint; others read as zero.
// - Base bits above output address size read zero, not stored.
// - Linear format aligns base clearing bits size plus five down to zero.
// - Two-level aligns base to max of 64 bytes or upper table size.
// - Alignment uses the raw programmed size, not the capped one.
// - Bit 62 is the read-allocate hint for table fetches.
// - With fixed tables, fields reset to chosen values.
// - Writes ignored while translation enable is one.
// - Registers writable only when enable and acknowledge are both zero.
// - Format 17:16, split 10:6, size 5:0; format and split zero without multi-level support.
// - Format 0 linear, 1 two-level, others act linear.
// - Split gives 6, 8 or 10 leaf bits; others act as 6.
// - Two-level upper index is id above split; leaf below split.
// - Upper level holds at least one descriptor.
// - Size is capped at identifier width for ranges and indices.
// - Out-of-range identifier aborts and may record an event.
// - Fetch attributes come from the second control register fields.
module stream_table_config
    import stream_table_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Register port.
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // Control state from the rest of the unit.
    input  wire logic        translation_enable,
    input  wire logic        control_zero_acknowledge,
    input  wire logic        tables_fixed,
    input  wire logic        multi_level_support,
    input  wire logic        record_invalid_id_enable,
    input  wire logic [3:0]  table_fetch_attr,
    // Lookup request.
    input  wire logic        lookup_valid,
    input  wire logic [15:0] lookup_stream_id,
    // Lookup answer.
    output logic             lookup_done,
    output logic             lookup_abort,
    output logic             out_of_range_id_event,
    output logic      [15:0] upper_index,
    output logic      [15:0] leaf_index,
    output logic      [51:0] fetch_base,
    output logic             fetch_read_alloc,
    output logic      [3:0]  fetch_attr
);

    logic [51:6] base_addr_r;
    logic        read_alloc_hint_r;
    logic [1:0]  table_format_r;
    logic [4:0]  split_r;
    logic [5:0]  table_size_exponent_r;
    logic        wr_allowed;
    logic        two_level;
    logic [4:0]  split_dec;
    logic [6:0]  align_top;
    logic [51:0] base_full;
    logic [51:0] base_aligned;
    logic [51:0] oas_mask;
    logic [31:0] rdata_nxt;

    lookup_if lk ();

    // Decodes a split encoding to its leaf bit count.
    function automatic logic [4:0] decode_split(input logic [4:0] enc);
        case (enc)
            SPLIT_4K, SPLIT_16K, SPLIT_64K: decode_split = enc;
            default:                        decode_split = SPLIT_4K;
        endcase
    endfunction

    assign wr_allowed = !tables_fixed && !translation_enable && !control_zero_acknowledge;

    assign oas_mask = (52'h1 << OUT_ADDR_BITS) - 52'h1;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            base_addr_r <= BASE_RESET[51:6];
        end else if (reg_write && wr_allowed && reg_addr == OFS_BASE_LO) begin
            base_addr_r[31:6] <= reg_wdata[31:6];
        end else if (reg_write && wr_allowed && reg_addr == OFS_BASE_HI) begin
            base_addr_r[51:32] <= reg_wdata[19:0] & oas_mask[51:32];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            read_alloc_hint_r <= BASE_RESET[BASE_RA_BIT];
        end else if (reg_write && wr_allowed && reg_addr == OFS_BASE_HI) begin
            read_alloc_hint_r <= reg_wdata[BASE_RA_BIT - 32];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            table_format_r        <= CFG_RESET[CFG_FMT_LSB +: 2];
            split_r               <= CFG_RESET[CFG_SPLIT_LSB +: 5];
            table_size_exponent_r <= CFG_RESET[CFG_SIZE_LSB +: 6];
        end else if (reg_write && wr_allowed && reg_addr == OFS_CFG) begin
            table_format_r        <= multi_level_support ? reg_wdata[CFG_FMT_LSB +: 2] : 2'h0;
            split_r               <= multi_level_support ? reg_wdata[CFG_SPLIT_LSB +: 5] : 5'h00;
            table_size_exponent_r <= reg_wdata[CFG_SIZE_LSB +: 6];
        end
    end

    assign two_level = (table_format_r == FMT_TWO_LV);
    assign split_dec = decode_split(split_r);

    always_comb begin
        if (!two_level) begin
            align_top = {1'b0, table_size_exponent_r} + LINEAR_ADD;
        end else if ({1'b0, table_size_exponent_r} + TWO_LV_ADD > {2'b00, split_dec} + MIN_ALIGN_TOP) begin
            align_top = {1'b0, table_size_exponent_r} + TWO_LV_ADD - {2'b00, split_dec};
        end else begin
            align_top = MIN_ALIGN_TOP;
        end
    end

    assign base_full = {base_addr_r, 6'h00} & oas_mask;
    assign base_aligned = (align_top >= 7'h33) ? 52'h0
                        : base_full & ~((52'h2 << align_top[5:0]) - 52'h1);

    assign lk.two_level  = two_level;
    assign lk.split_bits = split_dec;
    assign lk.size_raw   = table_size_exponent_r;
    assign lk.stream_id  = lookup_stream_id;

    stream_index_calc u_calc (
        .lk (lk.calc)
    );

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lookup_done           <= 1'b0;
            lookup_abort          <= 1'b0;
            out_of_range_id_event <= 1'b0;
        end else begin
            lookup_done           <= lookup_valid;
            lookup_abort          <= lookup_valid && lk.out_of_range;
            out_of_range_id_event <= lookup_valid && lk.out_of_range && record_invalid_id_enable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            upper_index      <= 16'h0000;
            leaf_index       <= 16'h0000;
            fetch_base       <= 52'h0;
            fetch_read_alloc <= 1'b0;
            fetch_attr       <= 4'h0;
        end else if (lookup_valid) begin
            upper_index      <= lk.upper_index;
            leaf_index       <= lk.leaf_index;
            fetch_base       <= base_aligned;
            fetch_read_alloc <= read_alloc_hint_r;
            fetch_attr       <= table_fetch_attr;
        end
    end

    // Readback shows the literal stored values.
    always_comb begin
        case (reg_addr)
            OFS_BASE_LO: rdata_nxt = {base_addr_r[31:6], 6'h00};
            OFS_BASE_HI: rdata_nxt = {1'b0, read_alloc_hint_r, 10'h000, base_addr_r[51:32]};
            OFS_CFG:     rdata_nxt = {14'h0000, table_format_r, 5'h00, split_r, table_size_exponent_r};
            default:     rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Assertions.
    AST_WRITE_BLOCKED: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && translation_enable && reg_addr == OFS_CFG) |=> $stable(table_size_exponent_r))
        else $error("configuration changed while enabled");

    AST_WRITE_TAKEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && wr_allowed && reg_addr == OFS_CFG)
        |=> table_size_exponent_r == $past(reg_wdata[5:0]))
        else $error("allowed write not stored");

    AST_LINEAR_ALIGN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!two_level && table_size_exponent_r < 6'h28)
        |-> (base_aligned & ((52'h1 << (table_size_exponent_r + 6'h06)) - 52'h1)) == 52'h0)
        else $error("linear base not aligned");

    AST_TWO_LV_MIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        two_level |-> base_aligned[5:0] == 6'h00)
        else $error("two-level base below 64 bytes");

    AST_ABORT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lookup_valid && lookup_stream_id >= (17'h1_0000 >> (6'h10 - lk.size_raw)) && lk.size_raw <= 6'h10)
        |=> lookup_abort && lookup_done)
        else $error("out of range id not aborted");

    AST_EVENT_GATED: assert property (@(posedge sys_clk) disable iff (!reset_n)
        out_of_range_id_event |-> lookup_abort && $past(record_invalid_id_enable))
        else $error("event recorded without permission");

    AST_RA_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lookup_valid |=> fetch_read_alloc == $past(read_alloc_hint_r))
        else $error("read allocate hint not forwarded");

    AST_NO_ML: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && wr_allowed && reg_addr == OFS_CFG && !multi_level_support)
        |=> table_format_r == 2'h0 && split_r == 5'h00)
        else $error("format stored without multi-level support");

    AST_LEAF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lookup_valid && two_level) |=> leaf_index == ($past(lookup_stream_id) & ((16'h1 << $past(split_dec)) - 16'h1)))
        else $error("leaf index wrong");

    AST_BASE_LO_STORE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && wr_allowed && reg_addr == OFS_BASE_LO)
        |=> base_addr_r[31:6] == $past(reg_wdata[31:6]))
        else $error("low base word not stored");

    // Bits above the output address size must never leak into a fetch address.
    AST_OAS_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (fetch_base & ~oas_mask) == 52'h0)
        else $error("fetch base above output address size");

    AST_RA_STORE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && wr_allowed && reg_addr == OFS_BASE_HI)
        |=> read_alloc_hint_r == $past(reg_wdata[BASE_RA_BIT - 32]))
        else $error("read allocate hint not stored");

    AST_RESET_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !$past(reset_n) |-> base_addr_r == BASE_RESET[51:6] && table_size_exponent_r == 6'h00 && !lookup_done)
        else $error("state not at reset value after reset");

    AST_FIXED_RO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && tables_fixed) |=> $stable(base_addr_r) && $stable(table_format_r))
        else $error("fixed tables were written");

    AST_ACK_RO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_write && control_zero_acknowledge) |=> $stable(split_r) && $stable(read_alloc_hint_r))
        else $error("write taken while acknowledge set");

    AST_LINEAR_UPPER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lookup_valid && table_format_r != FMT_TWO_LV) |=> upper_index == 16'h0000)
        else $error("linear lookup produced an upper index");

    AST_SPLIT_DEC: assert property (@(posedge sys_clk) disable iff (!reset_n)
        split_dec == SPLIT_4K || split_dec == SPLIT_16K || split_dec == SPLIT_64K)
        else $error("split decoded to unsupported width");

    // A split at or above the size leaves a single upper descriptor, index zero.
    AST_SINGLE_DESC: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lookup_valid && two_level && split_dec >= table_size_exponent_r[4:0] && table_size_exponent_r < 6'h20)
        |=> upper_index == 16'h0000)
        else $error("upper index not zero with one descriptor");

    AST_SIZE_CAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lookup_valid && table_size_exponent_r >= 6'h10) |=> !lookup_abort)
        else $error("abort although size covers every identifier");

    // Raw size above the identifier width still widens the linear alignment.
    AST_RAW_ALIGN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!two_level && table_size_exponent_r > 6'h10 && table_size_exponent_r < 6'h28)
        |-> base_aligned[21:0] == 22'h000000)
        else $error("alignment not taken from raw size");

    AST_ATTR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lookup_valid |=> fetch_attr == $past(table_fetch_attr))
        else $error("fetch attributes not forwarded");

    AST_COMB_BASE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lookup_valid |=> fetch_base == $past(base_aligned))
        else $error("fetch base not from current fields");

    AST_DONE_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lookup_done |-> $past(lookup_valid))
        else $error("done without a request");

    // Read data must stand until the next read strobe.
    AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !reg_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");

endmodule

// >>> tb/stream_table_config_tb.sv
// Purpose: Self-checking bench for the stream table configuration block.
// Assumes: One-cycle register and lookup latency, id width 16, output address size 48.
// Notes:   Expected values are built here from field positions, never read back from outputs.
module stream_table_config_tb
    import stream_table_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        reset_n;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        translation_enable;
    logic        control_zero_acknowledge;
    logic        tables_fixed;
    logic        multi_level_support;
    logic        record_invalid_id_enable;
    logic [3:0]  table_fetch_attr;
    logic        lookup_valid;
    logic [15:0] lookup_stream_id;
    logic        lookup_done;
    logic        lookup_abort;
    logic        out_of_range_id_event;
    logic [15:0] upper_index;
    logic [15:0] leaf_index;
    logic [51:0] fetch_base;
    logic        fetch_read_alloc;
    logic [3:0]  fetch_attr;
    int          err_count;
    int          checks;
    logic [51:0] base_full;
    logic [4:0]  split_code [5];
    int          split_eff  [5];
    logic [1:0]  lin_fmt    [3];

    stream_table_config dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .translation_enable(translation_enable),
        .control_zero_acknowledge(control_zero_acknowledge), .tables_fixed(tables_fixed),
        .multi_level_support(multi_level_support), .record_invalid_id_enable(record_invalid_id_enable),
        .table_fetch_attr(table_fetch_attr), .lookup_valid(lookup_valid), .lookup_stream_id(lookup_stream_id),
        .lookup_done(lookup_done), .lookup_abort(lookup_abort), .out_of_range_id_event(out_of_range_id_event),
        .upper_index(upper_index), .leaf_index(leaf_index), .fetch_base(fetch_base),
        .fetch_read_alloc(fetch_read_alloc), .fetch_attr(fetch_attr));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    function automatic logic [51:0] align(input logic [51:0] b, input int top);
        for (int i = 0; i < 52; i++) if (i <= top) b[i] = 1'b0;
        return b;
    endfunction

    function automatic logic [31:0] cfg(input logic [1:0] f, input logic [4:0] s, input logic [5:0] z);
        return {14'h0000, f, 5'h00, s, z};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp, "register readback");
    endtask

    task automatic lk(input logic [15:0] id, input logic ab, input logic ev, input logic ci,
                      input logic [15:0] up, input logic [15:0] lf, input logic [51:0] b, input logic ra);
        @(posedge sys_clk);
        lookup_valid     <= 1'b1;
        lookup_stream_id <= id;
        @(posedge sys_clk);
        lookup_valid <= 1'b0;
        #1;
        chk(lookup_done, 1'b1, "done");
        chk(lookup_abort, ab, "abort");
        chk(out_of_range_id_event, ev, "event");
        chk(fetch_base, b, "fetch base");
        chk(fetch_read_alloc, ra, "read alloc");
        chk(fetch_attr, table_fetch_attr, "attr");
        if (ci) begin
            chk(upper_index, up, "upper index");
            chk(leaf_index, lf, "leaf index");
        end
        @(posedge sys_clk);
        #1 chk(lookup_done, 1'b0, "done pulse");
    endtask

    task automatic endt(input string name);
        $display("test %s finished, %0d mismatches so far", name, err_count);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #2000000;
        err_count++;
        stop_test();
    end

    initial begin
        {reset_n, reg_write, reg_read, lookup_valid, translation_enable, control_zero_acknowledge} = 6'h00;
        {tables_fixed, record_invalid_id_enable} = 2'h0;
        {reg_addr, reg_wdata, lookup_stream_id} = 56'h0;
        multi_level_support = 1'b1;
        table_fetch_attr    = 4'hA;
        split_code = '{5'h06, 5'h08, 5'h0A, 5'h07, 5'h1F};
        split_eff  = '{6, 8, 10, 6, 6};
        lin_fmt    = '{2'h0, 2'h2, 2'h3};
        base_full  = 52'h0_FFFF_FFFF_FFC0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(OFS_BASE_LO, 32'h0000_0000);
        rd(OFS_BASE_HI, 32'h0000_0000);
        rd(OFS_CFG, 32'h0000_0000);
        rd(8'h8C, 32'h0000_0000);
        lk(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, 52'h0, 1'b0);
        endt("reset");
        wr(OFS_BASE_LO, 32'hFFFF_FFFF);
        wr(OFS_BASE_HI, 32'hFFFF_FFFF);
        rd(OFS_BASE_LO, 32'hFFFF_FFC0);
        rd(OFS_BASE_HI, 32'h4000_FFFF);
        wr(OFS_CFG, 32'hFFFF_FFFF);
        rd(OFS_CFG, 32'h0003_07FF);
        @(posedge sys_clk);
        multi_level_support <= 1'b0;
        wr(OFS_CFG, 32'hFFFF_FFFF);
        rd(OFS_CFG, 32'h0000_003F);
        @(posedge sys_clk);
        multi_level_support <= 1'b1;
        endt("fields");
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            {tables_fixed, translation_enable, control_zero_acknowledge} <= 3'b100 >> k;
            wr(OFS_BASE_LO, 32'h0000_0000);
            wr(OFS_CFG, cfg(2'h1, 5'h08, 6'h04));
            rd(OFS_BASE_LO, 32'hFFFF_FFC0);
            rd(OFS_CFG, 32'h0000_003F);
        end
        @(posedge sys_clk);
        {tables_fixed, translation_enable, control_zero_acknowledge} <= 3'b000;
        endt("write guard");
        record_invalid_id_enable <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_CFG, cfg(lin_fmt[k], 5'h08, 6'h0A));
            lk(16'h03FF, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, align(base_full, 15), 1'b1);
            lk(16'h0400, 1'b1, 1'b1, 1'b0, 16'h0, 16'h0, align(base_full, 15), 1'b1);
        end
        wr(OFS_CFG, cfg(2'h0, 5'h06, 6'h14));
        lk(16'hFFFF, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, align(base_full, 25), 1'b1);
        wr(OFS_CFG, cfg(2'h0, 5'h06, 6'h32));
        lk(16'h1234, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, 52'h0, 1'b1);
        endt("linear");
        for (int k = 0; k < 5; k++) begin
            wr(OFS_CFG, cfg(2'h1, split_code[k], 6'h10));
            lk(16'hABCD, 1'b0, 1'b0, 1'b1, 16'hABCD >> split_eff[k], 16'hABCD & ((16'h1 << split_eff[k]) - 16'h1),
               align(base_full, 18 - split_eff[k]), 1'b1);
        end
        wr(OFS_CFG, cfg(2'h1, 5'h06, 6'h14));
        lk(16'hFFFF, 1'b0, 1'b0, 1'b1, 16'h03FF, 16'h003F, align(base_full, 16), 1'b1);
        wr(OFS_CFG, cfg(2'h1, 5'h08, 6'h04));
        lk(16'h000F, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h000F, align(base_full, 5), 1'b1);
        @(posedge sys_clk);
        record_invalid_id_enable <= 1'b0;
        table_fetch_attr         <= 4'h5;
        lk(16'h0010, 1'b1, 1'b0, 1'b0, 16'h0, 16'h0, align(base_full, 5), 1'b1);
        endt("two level");
        wr(OFS_BASE_HI, 32'h0000_1234);
        rd(OFS_BASE_HI, 32'h0000_1234);
        lk(16'h0003, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0003, 52'h0_1234_FFFF_FFC0, 1'b0);
        endt("read alloc");
        stop_test();
    end
endmodule
